// >>> verif/nv_array_protection_asserts.sv
// checker on the apb ports of the array protection block
// assumes one clock and a synchronous high reset
`timescale 1ns/100ps
module nv_array_protection_asserts (
	input wire logic        i_clock,   // clock
	input wire logic        i_reset,   // reset
	input wire logic        i_psel,    // select
	input wire logic        i_penable, // access
	input wire logic        i_pwrite,  // direction
	input wire logic [7:0]  i_paddr,   // address
	input wire logic [31:0] i_pwdata,  // write data
	input wire logic        o_pready,  // ready
	input wire logic        o_pslverr, // error
	input wire logic [31:0] o_prdata,  // read data
	input wire logic        o_irq      // interrupt
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_reset);
	logic open_clr_r;
	logic dis_clr_r;
	wire  rd_prot = o_pready && !i_pwrite && i_paddr == 8'h00;
	// remember writes that cleared open or disable; only reset may set them again
	always @(posedge i_clock) begin
		if (i_reset) begin
			open_clr_r <= 1'b0;
			dis_clr_r  <= 1'b0;
		end else if (o_pready && i_pwrite && i_paddr == 8'h00) begin
			if (!i_pwdata[7]) open_clr_r <= 1'b1;
			if (!i_pwdata[3]) dis_clr_r <= 1'b1;
		end
	end
	a_ready_in_access: assert property (o_pready |-> i_psel && i_penable) else $error("ready outside access");
	a_ready_one_cycle: assert property (o_pready |=> !o_pready) else $error("ready held");
	a_reset_quiet: assert property (disable iff (1'b0)
		i_reset && $past(i_reset) |-> !o_pready && !o_irq && o_prdata == 32'h0) else $error("busy in reset");
	a_ready_bounded: assert property (i_psel && $rose(i_penable) |-> ##[0:8] o_pready) else $error("no ready");
	a_unmapped_err: assert property (o_pready && i_paddr == 8'h20 |-> o_pslverr) else $error("unmapped ok");
	a_clear_read_err: assert property (o_pready && !i_pwrite && i_paddr == 8'h0c |-> o_pslverr) else $error("clr read");
	a_prot_byte_wide: assert property (rd_prot |-> o_prdata[31:8] == 24'h0) else $error("wide prot");
	a_open_stays_clear: assert property (rd_prot && open_clr_r |-> !o_prdata[7]) else $error("open set");
	a_dis_stays_clear: assert property (rd_prot && dis_clr_r |-> !o_prdata[3]) else $error("dis set");
	c_mass_erase: cover property (o_pready && i_pwrite && i_paddr == 8'h18 && i_pwdata[2:0] == 3'h3);
	c_error: cover property (o_pready && o_pslverr);
	c_irq: cover property ($rose(o_irq));
endmodule
bind nv_array_protection nv_array_protection_asserts u_chk (.i_clock(i_clock), .i_reset(i_reset),
	.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
	.o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata), .o_irq(o_irq));

// >>> verif/tb_nv_array_protection.sv
// directed apb bench for the array protection block
// assumes the array starts erased and keeps its contents over reset
`timescale 1ns/100ps
module tb_nv_array_protection;
	logic        i_clock;
	logic        i_reset;
	logic        i_psel;
	logic        i_penable;
	logic        i_pwrite;
	logic [7:0]  i_paddr;
	logic [31:0] i_pwdata;
	logic [31:0] rd;
	logic        err;
	wire         o_pready;
	wire         o_pslverr;
	wire         o_irq;
	wire  [31:0] o_prdata;
	int          error_cnt = 0;
	int          n_tests = 0;
	// short program time keeps polling loops brief
	nv_array_protection #(.PROG_CYCLES(4)) u_dut (.i_clock(i_clock), .i_reset(i_reset), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata), .o_irq(o_irq));
	initial begin
		i_clock = 1'h0;
		forever #4 i_clock = ~i_clock;
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wrap_up;
		if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// one apb transfer; request held until ready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_psel <= 1'h1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clock);
		i_penable <= 1'h1;
		do @(posedge i_clock); while (o_pready !== 1'h1);
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'h0;
		i_penable <= 1'h0;
	endtask
	// address, data, command, then poll busy; rd ends as status
	task automatic op(input logic [31:0] a, input logic [31:0] d, input logic [31:0] c);
		apb(1'h1, 8'h10, a);
		apb(1'h1, 8'h14, d);
		apb(1'h1, 8'h18, c);
		do apb(1'h0, 8'h04, 32'h0); while (rd[8] !== 1'h0);
	endtask
	task automatic rdb(input logic [31:0] a, input logic [31:0] e);
		op(a, 32'h0, 32'h4);
		apb(1'h0, 8'h14, 32'h0);
		chk("byte", rd, e);
	endtask
	// interrupt is looked at mid-cycle, after the edge that committed the last write has settled
	task automatic irq_now(input logic e);
		@(negedge i_clock);
		chk("irq", o_irq, e);
	endtask
	task automatic prot(input logic [31:0] d, input logic [31:0] e);
		apb(1'h1, 8'h00, d);
		apb(1'h0, 8'h00, 32'h0);
		chk("prot", rd, e);
	endtask
	initial begin
		#480000;
		error_cnt++;
		wrap_up;
	end
	initial begin
		{i_reset, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = {1'h1, 43'h0};
		repeat (6) @(posedge i_clock);
		i_reset <= 1'h0;
		apb(1'h0, 8'h00, 32'h0);
		chk("load", rd, 32'hff);
		apb(1'h1, 8'h08, 32'h3);
		op(32'h5, 32'h5a, 32'h1);
		chk("status", rd, 32'h2);
		irq_now(1'h1);
		apb(1'h1, 8'h0c, 32'h3);
		irq_now(1'h0);
		op(32'h0, 32'h0, 32'h3);
		chk("viol", rd[0], 1'h0);
		rdb(32'h5, 32'hff);
		op(32'hffd, 32'ha9, 32'h1);
		rdb(32'hffd, 32'ha9);
		prot(32'h8d, 32'hfd);
		prot(32'h82, 32'hf2);
		prot(32'h8f, 32'hf2);
		apb(1'h1, 8'h08, 32'h0);
		apb(1'h1, 8'h0c, 32'h3);
		op(32'hf3f, 32'h11, 32'h1);
		op(32'hf40, 32'h22, 32'h1);
		chk("viol", rd[0], 1'h1);
		irq_now(1'h0);
		apb(1'h1, 8'h08, 32'h3);
		irq_now(1'h1);
		rdb(32'hf3f, 32'h11);
		rdb(32'hf40, 32'hff);
		apb(1'h1, 8'h0c, 32'h3);
		op(32'h0, 32'h0, 32'h3);
		chk("viol", rd[0], 1'h1);
		rdb(32'hf3f, 32'h11);
		prot(32'h0, 32'h72);
		apb(1'h1, 8'h0c, 32'h3);
		op(32'h6, 32'h33, 32'h1);
		chk("viol", rd[0], 1'h1);
		rdb(32'h6, 32'hff);
		apb(1'h0, 8'h20, 32'h0);
		chk("unmapped", err, 1'h1);
		apb(1'h0, 8'h0c, 32'h0);
		chk("clr read", err, 1'h1);
		apb(1'h1, 8'h18, 32'h7);
		chk("bad cmd", err, 1'h1);
		i_reset <= 1'h1;
		repeat (6) @(posedge i_clock);
		i_reset <= 1'h0;
		apb(1'h0, 8'h00, 32'h0);
		chk("reload", rd, 32'ha9);
		wrap_up;
	end
endmodule

// >>> verilog/nv_array_mem.v
// byte array for the nonvolatile store, one address port shared by the write and the registered read
// assumes the caller ignores read data captured in a write cycle, which is the old byte
`timescale 1ns/100ps
module nv_array_mem #(
	parameter AW = 12,
	parameter DW = 8
) (
	input  wire          i_clock,  // system clock
	input  wire          i_we,     // write strobe
	input  wire [AW-1:0] i_addr,   // byte address
	input  wire [DW-1:0] i_wdata,  // write data
	output reg  [DW-1:0] o_rdata   // registered read data
);
	reg [DW-1:0] mem [0:(1<<AW)-1];
	integer k;

	// start erased so the reload sees an open array in simulation
	initial begin
		for (k = 0; k < (1<<AW); k = k + 1)
			mem[k] = {DW{1'b1}};
	end

	// read data one cycle after the address
	always @(posedge i_clock) begin
		if (i_we)
			mem[i_addr] <= i_wdata;
		o_rdata <= mem[i_addr];
	end
endmodule

// >>> verilog/nv_array_protection.v
// protection, command engine and APB register file for the nonvolatile array
// assumes a single clock, synchronous reset and an APB master on the same clock
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`include "nv_protect_defs.vh"
module nv_array_protection #(
	parameter        AW          = 12,
	parameter        PROG_CYCLES = `PROG_CYCLES,
	parameter [95:0] SIZE_TABLE  = `SIZE_TABLE
) (
	input  wire        i_clock,    // system bus clock
	input  wire        i_reset,    // synchronous reset, high
	input  wire        i_psel,     // apb select
	input  wire        i_penable,  // apb access phase
	input  wire        i_pwrite,   // apb direction
	input  wire [7:0]  i_paddr,    // apb byte address
	input  wire [31:0] i_pwdata,   // apb write data
	output wire        o_pready,   // apb ready
	output wire        o_pslverr,  // apb error
	output reg  [31:0] o_prdata,   // apb read data
	output wire        o_irq       // level interrupt
);
	localparam S_LOAD_ADDR = 3'd0;
	localparam S_LOAD_CAP  = 3'd1;
	localparam S_IDLE      = 3'd2;
	localparam S_PROG      = 3'd3;
	localparam S_MASS      = 3'd4;
	localparam S_READ      = 3'd5;
	localparam [AW-1:0] TOP_ADDR = {AW{1'b1}};
	localparam [AW:0]   DEPTH    = {1'b1, {AW{1'b0}}};
	localparam [15:0]   PROG_LAST = PROG_CYCLES - 1;

	reg  [2:0]    state_r;
	reg  [2:0]    state_nxt;
	reg           open_r;
	reg           dis_r;
	reg  [2:0]    size_r;
	reg  [2:0]    uflags_r;
	reg  [`EVENT_WIDTH-1:0] status_r;
	reg  [`EVENT_WIDTH-1:0] enable_r;
	reg  [AW-1:0] addr_r;
	reg  [7:0]    data_r;
	reg  [7:0]    rdbyte_r;
	reg  [2:0]    op_r;
	reg  [15:0]   cnt_r;
	reg  [AW-1:0] mass_r;
	reg           ack_r;
	reg           err_r;

	wire [7:0]    mem_rdata;
	reg           mem_we;
	reg  [AW-1:0] mem_addr;
	reg  [7:0]    mem_wdata;

	wire [7:0] prot_value = {open_r, uflags_r, dis_r, size_r};
	wire       busy       = (state_r != S_IDLE);
	wire       loading    = (state_r == S_LOAD_ADDR) || (state_r == S_LOAD_CAP);
	wire       access     = i_psel && i_penable;
	wire       commit     = access && ack_r;
	wire       bus_wr     = commit && i_pwrite;

	// protected byte count for a size code
	// size table lookup
	function [AW:0] region_bytes;
		input [2:0] code;
		begin
			region_bytes = {1'b0, SIZE_TABLE[code*12 +: AW]};
		end
	endfunction

	// true when program or erase of an address is refused
	function addr_protected;
		input [AW-1:0] a;
		input          open_bit;
		input          dis_bit;
		input [2:0]    code;
		begin
			if (!open_bit)
				addr_protected = 1'b1;
			else if (dis_bit)
				addr_protected = 1'b0;
			else
				addr_protected = ({1'b0, a} >= (DEPTH - region_bytes(code)));
		end
	endfunction

	// address decode of the register map
	function mapped;
		input [7:0] a;
		begin
			mapped = (a == `OFS_PROTECT) || (a == `OFS_STATUS) || (a == `OFS_IRQ_ENABLE) ||
				(a == `OFS_STATUS_CLR) || (a == `OFS_ADDRESS) || (a == `OFS_DATA) ||
				(a == `OFS_COMMAND);
		end
	endfunction

	wire [2:0] cmd       = i_pwdata[2:0];
	wire       cmd_wr    = bus_wr && (i_paddr == `OFS_COMMAND);
	wire       cmd_valid = (cmd == `CMD_PROGRAM) || (cmd == `CMD_ERASE) ||
		(cmd == `CMD_MASS_ERASE) || (cmd == `CMD_READ);
	wire       cmd_go    = cmd_wr && !busy && cmd_valid;
	wire       hit_prot  = addr_protected(addr_r, open_r, dis_r, size_r);
	// mass erase needs both bits set
	wire       mass_ok   = open_r && dis_r;
	wire       refuse    = cmd_go && (((cmd == `CMD_PROGRAM || cmd == `CMD_ERASE) && hit_prot) ||
		((cmd == `CMD_MASS_ERASE) && !mass_ok));
	wire       accept    = cmd_go && !refuse;
	wire       prog_end  = (state_r == S_PROG) && (cnt_r == PROG_LAST);
	wire       mass_end  = (state_r == S_MASS) && (mass_r == TOP_ADDR);
	wire       done_ev   = prog_end || mass_end || (state_r == S_READ);

	// state sequence; a refused command never leaves idle
	always @* begin
		state_nxt = state_r;
		case (state_r)
			S_LOAD_ADDR: state_nxt = S_LOAD_CAP;
			S_LOAD_CAP:  state_nxt = S_IDLE;
			S_IDLE: begin
				if (accept) begin
					if (cmd == `CMD_MASS_ERASE)
						state_nxt = S_MASS;
					else if (cmd == `CMD_READ)
						state_nxt = S_READ;
					else
						state_nxt = S_PROG;
				end
			end
			S_PROG: begin
				if (prog_end)
					state_nxt = S_IDLE;
			end
			S_MASS: begin
				if (mass_end)
					state_nxt = S_IDLE;
			end
			S_READ:      state_nxt = S_IDLE;
			default:     state_nxt = S_IDLE;
		endcase
	end

	// array port steering; program and erase write at the end of the operation, mass erase writes every cycle of its sweep
	always @* begin
		mem_we    = 1'b0;
		mem_addr  = addr_r;
		mem_wdata = `ERASED_BYTE;
		case (state_r)
			S_LOAD_ADDR: mem_addr = `PROT_BYTE_ADDR;
			S_LOAD_CAP:  mem_addr = `PROT_BYTE_ADDR;
			S_PROG: begin
				mem_we    = prog_end;
				mem_wdata = (op_r == `CMD_PROGRAM) ? data_r : `ERASED_BYTE;
			end
			S_MASS: begin
				mem_we   = 1'b1;
				mem_addr = mass_r;
			end
			default: mem_addr = addr_r;
		endcase
	end

	nv_array_mem #(
		.AW (AW),
		.DW (8)
	) u_mem (
		.i_clock (i_clock),
		.i_we    (mem_we),
		.i_addr  (mem_addr),
		.i_wdata (mem_wdata),
		.o_rdata (mem_rdata)
	);

	// engine registers
	always @(posedge i_clock) begin
		if (i_reset) begin
			state_r <= S_LOAD_ADDR;
			op_r    <= 3'h0;
			cnt_r   <= 16'h0000;
			mass_r  <= {AW{1'b0}};
		end else begin
			state_r <= state_nxt;
			if (accept) begin
				op_r   <= cmd;
				cnt_r  <= 16'h0000;
				mass_r <= {AW{1'b0}};
			end else begin
				if (state_r == S_PROG)
					cnt_r <= cnt_r + 16'h0001;
				if (state_r == S_MASS)
					mass_r <= mass_r + {{(AW-1){1'b0}}, 1'b1};
			end
		end
	end

	// protection register: loaded after reset, tightened by software
	always @(posedge i_clock) begin
		if (i_reset) begin
			open_r   <= 1'b0;
			dis_r    <= 1'b0;
			size_r   <= 3'h7;
			uflags_r <= 3'h7;
		end else if (state_r == S_LOAD_CAP) begin
			open_r   <= mem_rdata[`PROT_OPEN_BIT];
			uflags_r <= mem_rdata[`PROT_FLAG_HI:`PROT_FLAG_LO];
			dis_r    <= mem_rdata[`PROT_DIS_BIT];
			size_r   <= mem_rdata[`PROT_SIZE_HI:`PROT_SIZE_LO];
		end else if (bus_wr && (i_paddr == `OFS_PROTECT)) begin
			open_r <= open_r & i_pwdata[`PROT_OPEN_BIT];
			dis_r  <= dis_r & i_pwdata[`PROT_DIS_BIT];
			if (dis_r)
				size_r <= i_pwdata[`PROT_SIZE_HI:`PROT_SIZE_LO];
		end
	end

	// address, data and read-back byte
	always @(posedge i_clock) begin
		if (i_reset) begin
			addr_r   <= {AW{1'b0}};
			data_r   <= 8'h00;
			rdbyte_r <= 8'h00;
		end else begin
			// writes while busy would disturb the running operation
			if (bus_wr && !busy && (i_paddr == `OFS_ADDRESS))
				addr_r <= i_pwdata[AW-1:0];
			if (bus_wr && !busy && (i_paddr == `OFS_DATA))
				data_r <= i_pwdata[7:0];
			if (state_r == S_READ)
				rdbyte_r <= mem_rdata;
		end
	end

	// sticky events; a new event beats a clear in the same cycle
	always @(posedge i_clock) begin
		if (i_reset) begin
			status_r <= {`EVENT_WIDTH{1'b0}};
			enable_r <= {`EVENT_WIDTH{1'b0}};
		end else begin
			status_r[`ST_VIOL_BIT] <= refuse ||
				(status_r[`ST_VIOL_BIT] && !(bus_wr && (i_paddr == `OFS_STATUS_CLR) && i_pwdata[`ST_VIOL_BIT]));
			status_r[`ST_DONE_BIT] <= done_ev ||
				(status_r[`ST_DONE_BIT] && !(bus_wr && (i_paddr == `OFS_STATUS_CLR) && i_pwdata[`ST_DONE_BIT]));
			if (bus_wr && (i_paddr == `OFS_IRQ_ENABLE))
				enable_r <= i_pwdata[`EVENT_WIDTH-1:0];
		end
	end

	assign o_irq = |(status_r & enable_r);

	// apb: one wait state, ready held off while the reload runs
	always @(posedge i_clock) begin
		if (i_reset) begin
			ack_r    <= 1'b0;
			err_r    <= 1'b0;
			o_prdata <= 32'h0000_0000;
		end else begin
			ack_r <= access && !ack_r && !loading;
			if (access && !ack_r) begin
				err_r <= !mapped(i_paddr) || (i_pwrite && (i_paddr == `OFS_COMMAND) && (busy || !cmd_valid)) ||
					(!i_pwrite && (i_paddr == `OFS_STATUS_CLR));
				case (i_paddr)
					`OFS_PROTECT:    o_prdata <= {24'h000000, prot_value};
					`OFS_STATUS:     o_prdata <= {23'h000000, busy, {(8-`EVENT_WIDTH){1'b0}}, status_r};
					`OFS_IRQ_ENABLE: o_prdata <= {{(32-`EVENT_WIDTH){1'b0}}, enable_r};
					`OFS_ADDRESS:    o_prdata <= {{(32-AW){1'b0}}, addr_r};
					`OFS_DATA:       o_prdata <= {24'h000000, rdbyte_r};
					`OFS_COMMAND:    o_prdata <= {29'h00000000, op_r};
					default:         o_prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign o_pready  = ack_r;
	assign o_pslverr = ack_r && err_r;
endmodule

// >>> verilog/nv_protect_defs.vh
// constants for the nonvolatile array protection block
// assumes a 4 Kbyte byte-wide array and an APB slave with 32-bit data
// What this block does
// - reset reloads protection from array byte 0x0ffd
// - all bits readable, user flags ignore writes
// - open and disable bits only clear
// - size field writable while disable bit set
// - open bit zero protects whole array
// - open bit one allows unprotected sectors
// - disable bit zero enables protected range
// - size field picks protected top sector
// - protected program or erase refused, flag set
// - mass erase only when fully unprotected
// - refused mass erase sets violation flag
// - user flags come from stored byte only
`ifndef NV_PROTECT_DEFS_VH
`define NV_PROTECT_DEFS_VH

// register byte offsets
`define OFS_PROTECT     8'h00
`define OFS_STATUS      8'h04
`define OFS_IRQ_ENABLE  8'h08
`define OFS_STATUS_CLR  8'h0c
`define OFS_ADDRESS     8'h10
`define OFS_DATA        8'h14
`define OFS_COMMAND     8'h18

// protection register fields
`define PROT_OPEN_BIT   7
`define PROT_FLAG_HI    6
`define PROT_FLAG_LO    4
`define PROT_DIS_BIT    3
`define PROT_SIZE_HI    2
`define PROT_SIZE_LO    0

// array location of the stored protection byte
`define PROT_BYTE_ADDR  12'hffd

// status bits
`define ST_VIOL_BIT     0
`define ST_DONE_BIT     1
`define ST_BUSY_BIT     8
`define EVENT_WIDTH     2

// commands
`define CMD_PROGRAM     3'h1
`define CMD_ERASE       3'h2
`define CMD_MASS_ERASE  3'h3
`define CMD_READ        3'h4

// timing and values
`define PROG_CYCLES     16
`define ERASED_BYTE     8'hff
// entry n (12 bits each) is the protected byte count for size code n
`define SIZE_TABLE      96'h200_1c0_180_140_100_0c0_080_040

`endif
